// ### design/flut_regs.svh
// register indices, field positions and reset values of the upper fan table entries
`ifndef FLUT_REGS_SVH
`define FLUT_REGS_SVH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define FLUT_IDX_LOCK     8'h4a
`define FLUT_IDX_OFFSET   8'h4e
`define FLUT_IDX_THR11    8'h64
`define FLUT_IDX_DUTY11   8'h65
`define FLUT_IDX_THR12    8'h66
`define FLUT_IDX_DUTY12   8'h67
`define FLUT_IDX_MODE     8'h70
`define FLUT_IDX_STATUS   8'h71

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define FLUT_LOCK_WREN_BIT  5
`define FLUT_MODE_TEMP_HR   0
`define FLUT_MODE_DUTY_HR   1
`define FLUT_MODE_PWM_22K5  2
`define FLUT_THR_HALF_BIT   7
`define FLUT_DUTY_EXT_HI    7
`define FLUT_DUTY_EXT_LO    6

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define FLUT_RST_THR      8'h7f
`define FLUT_RST_DUTY     8'h3f
`define FLUT_RST_LOCK     8'h00
`define FLUT_RST_OFFSET   8'h00
`define FLUT_RST_MODE     8'h00

`endif

// ### design/flut_pkg.sv
// types shared by the upper fan table entry logic
package flut_pkg;

  // ----------------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------------
  typedef logic [7:0] flut_byte_t;   // one table register

  // which upper entry currently owns the pwm duty
  typedef enum logic [1:0] {
    FLUT_SEL_NONE,
    FLUT_SEL_11,
    FLUT_SEL_12
  } flut_sel_e;

endpackage

// ### design/flut_upper.sv
// upper fan speed table entries 11 and 12 with avalon-mm register access
//
// Function
// - low temp resolution: threshold top bit zero
// - high temp resolution: nine bit half degree compare
// - low temp resolution: eight bit whole degree compare
// - temperature above threshold selects entry duty
// - thresholds always non-negative, sign assumed zero
// - table offset register shifts effective thresholds
// - low duty resolution: duty top bits zero
// - high duty resolution: extended plus base bits
// - extended duty bits only at 22.5 kHz
// - low resolution duty from lower six bits
//
// The Avalon-MM interface to the registers is this design's own decision.

`include "flut_regs.svh"

module flut_upper
  import flut_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [8:0]  remote_temp,
  output logic             table_hit,
  output logic      [7:0]  table_duty
);

  // ----------------------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------------------
  flut_byte_t thr11_q;     // entry 11 threshold
  flut_byte_t duty11_q;    // entry 11 duty
  flut_byte_t thr12_q;     // entry 12 threshold
  flut_byte_t duty12_q;    // entry 12 duty
  flut_byte_t lock_q;      // table lock control
  flut_byte_t offset_q;    // table temperature offset, whole degrees
  flut_byte_t mode_q;      // resolution and frequency controls
  logic       ack_q;       // bus answer phase
  flut_sel_e  sel_q;       // entry owning the duty
  logic [7:0] duty_q;      // registered duty output

  // ----------------------------------------------------------------------------
  // decoded controls
  // ----------------------------------------------------------------------------
  logic       temp_hr;     // half degree thresholds
  logic       duty_hr;     // eight bit duty table
  logic       pwm_22k5;    // 22.5 khz pwm selected
  logic       ext_en;      // extended duty bits active
  logic       wr_en;       // software may write the entries
  logic       req;         // any bus request
  logic       acc;         // request completes this edge
  logic       wr_acc;      // write takes effect this edge
  logic [7:0] idx;         // register index of the request
  logic       lane0;       // low byte lane enabled
  logic [7:0] wbyte;       // write data of the low lane

  // mode bits decode straight from the stored control byte
  assign temp_hr  = mode_q[`FLUT_MODE_TEMP_HR];
  assign duty_hr  = mode_q[`FLUT_MODE_DUTY_HR];
  assign pwm_22k5 = mode_q[`FLUT_MODE_PWM_22K5];
  assign ext_en   = duty_hr & pwm_22k5;
  assign wr_en    = lock_q[`FLUT_LOCK_WREN_BIT];
  assign req      = avs_read | avs_write;
  assign acc      = req & ack_q;
  assign wr_acc   = acc & avs_write & lane0;
  assign idx      = avs_address[9:2];
  assign lane0    = avs_byteenable[0];
  assign wbyte    = avs_writedata[7:0];

  // ----------------------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------------------
  // waitrequest stands one cycle, released for the completing edge
  assign avs_waitrequest = req & ~ack_q;

  // a request still held after completion restarts with a fresh wait cycle
  // answer phase toggles once per request
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // ----------------------------------------------------------------------------
  // thresholds
  // ----------------------------------------------------------------------------
  // write only when unlocked; top bit cleared in low resolution
  // the clear follows the write, so a low resolution write never sets bit 7
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      thr11_q <= `FLUT_RST_THR;
      thr12_q <= `FLUT_RST_THR;
    end else begin
      if (wr_acc && wr_en && idx == `FLUT_IDX_THR11) begin
        thr11_q <= wbyte;
      end
      if (wr_acc && wr_en && idx == `FLUT_IDX_THR12) begin
        thr12_q <= wbyte;
      end
      if (!temp_hr) begin
        thr11_q[`FLUT_THR_HALF_BIT] <= 1'b0;
        thr12_q[`FLUT_THR_HALF_BIT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // duty values
  // ----------------------------------------------------------------------------
  // write only when unlocked; extended bits cleared in low resolution
  // the clear follows the write, so low resolution writes never set bits 7:6
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      duty11_q <= `FLUT_RST_DUTY;
      duty12_q <= `FLUT_RST_DUTY;
    end else begin
      if (wr_acc && wr_en && idx == `FLUT_IDX_DUTY11) begin
        duty11_q <= wbyte;
      end
      if (wr_acc && wr_en && idx == `FLUT_IDX_DUTY12) begin
        duty12_q <= wbyte;
      end
      if (!duty_hr) begin
        duty11_q[`FLUT_DUTY_EXT_HI:`FLUT_DUTY_EXT_LO] <= 2'b00;
        duty12_q[`FLUT_DUTY_EXT_HI:`FLUT_DUTY_EXT_LO] <= 2'b00;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // lock, offset and mode controls
  // ----------------------------------------------------------------------------
  // these stay writable so software can unlock the table
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_q   <= `FLUT_RST_LOCK;
      offset_q <= `FLUT_RST_OFFSET;
      mode_q   <= `FLUT_RST_MODE;
    end else if (wr_acc) begin
      if (idx == `FLUT_IDX_LOCK) begin
        lock_q <= wbyte;
      end
      if (idx == `FLUT_IDX_OFFSET) begin
        offset_q <= wbyte;
      end
      if (idx == `FLUT_IDX_MODE) begin
        mode_q <= {5'h00, wbyte[2:0]};
      end
    end
  end

  // ----------------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------------
  // loaded while waitrequest is high, stands at the completing edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      unique case (idx)
        `FLUT_IDX_THR11:  avs_readdata <= {24'h000000, thr11_q};
        `FLUT_IDX_DUTY11: avs_readdata <= {24'h000000, duty11_q};
        `FLUT_IDX_THR12:  avs_readdata <= {24'h000000, thr12_q};
        `FLUT_IDX_DUTY12: avs_readdata <= {24'h000000, duty12_q};
        `FLUT_IDX_LOCK:   avs_readdata <= {24'h000000, lock_q};
        `FLUT_IDX_OFFSET: avs_readdata <= {24'h000000, offset_q};
        `FLUT_IDX_MODE:   avs_readdata <= {24'h000000, mode_q};
        // status reports which entry owns the duty
        `FLUT_IDX_STATUS: avs_readdata <= {24'h000000, 6'h00, sel_q};
        // unmapped index reads as zero
        default:          avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // effective thresholds, in half degrees, ten bits
  // ----------------------------------------------------------------------------
  logic [9:0] eff11;       // entry 11 limit
  logic [9:0] eff12;       // entry 12 limit
  logic [9:0] temp_cmp;    // reading at the active resolution
  logic       over11;      // reading above entry 11
  logic       over12;      // reading above entry 12

  // limits and reading at the active temperature resolution
  always_comb begin
    if (temp_hr) begin
      eff11 = {2'b00, thr11_q[6:0], thr11_q[7]} + {1'b0, offset_q, 1'b0};
      eff12 = {2'b00, thr12_q[6:0], thr12_q[7]} + {1'b0, offset_q, 1'b0};
      temp_cmp = {1'b0, remote_temp};
    end else begin
      eff11 = {2'b00, thr11_q[6:0], 1'b0} + {1'b0, offset_q, 1'b0};
      eff12 = {2'b00, thr12_q[6:0], 1'b0} + {1'b0, offset_q, 1'b0};
      temp_cmp = {1'b0, remote_temp[8:1], 1'b0};
    end
  end

  assign over11 = temp_cmp > eff11;
  assign over12 = temp_cmp > eff12;

  // ----------------------------------------------------------------------------
  // duty words of each entry
  // ----------------------------------------------------------------------------
  logic [7:0] dv11;        // entry 11 duty in force
  logic [7:0] dv12;        // entry 12 duty in force

  // duty words at the active duty resolution
  always_comb begin
    if (ext_en) begin
      dv11 = duty11_q;
      dv12 = duty12_q;
    end else begin
      dv11 = {2'b00, duty11_q[5:0]};
      dv12 = {2'b00, duty12_q[5:0]};
    end
  end

  // ----------------------------------------------------------------------------
  // entry selection
  // ----------------------------------------------------------------------------
  // the higher entry wins when both limits are exceeded
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_q  <= FLUT_SEL_NONE;
      duty_q <= 8'h00;
    end else if (over12) begin
      sel_q  <= FLUT_SEL_12;
      duty_q <= dv12;
    end else if (over11) begin
      sel_q  <= FLUT_SEL_11;
      duty_q <= dv11;
    end else begin
      sel_q  <= FLUT_SEL_NONE;
      duty_q <= 8'h00;
    end
  end

  // hit flag decodes from the sel_q flip-flops, duty comes straight from flip-flops
  assign table_hit  = sel_q != FLUT_SEL_NONE;
  assign table_duty = duty_q;

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  // all checks run on clk and sleep through reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_locked_thr_write: assert property (
    wr_acc && !wr_en && idx == `FLUT_IDX_THR11 |=> thr11_q == $past(thr11_q))
    else $error("threshold 11 changed while locked");

  chk_locked_duty_write: assert property (
    wr_acc && !wr_en && idx == `FLUT_IDX_DUTY11 |=> duty11_q == $past(duty11_q))
    else $error("duty 11 changed while locked");

  chk_unlocked_duty_write: assert property (
    wr_acc && wr_en && idx == `FLUT_IDX_DUTY12 && duty_hr
      |=> duty12_q == $past(wbyte))
    else $error("duty 12 write lost while unlocked");

  chk_thr_half_low: assert property (
    !temp_hr [*2] |-> !thr11_q[7] && !thr12_q[7])
    else $error("threshold top bit set in low resolution");

  chk_lr_thr_write: assert property (
    wr_acc && wr_en && idx == `FLUT_IDX_THR12 && !temp_hr |=> !thr12_q[7])
    else $error("low resolution write set threshold top bit");

  chk_hr_compare: assert property (
    temp_hr && offset_q == 8'h00 && remote_temp == {thr11_q[6:0], thr11_q[7]} + 9'h001
      |-> over11)
    else $error("half degree compare wrong");

  chk_lr_compare: assert property (
    !temp_hr && remote_temp[8:1] == {1'b0, thr11_q[6:0]} && offset_q == 8'h00
      |-> !over11)
    else $error("whole degree compare used half bit");

  chk_entry_duty: assert property (
    over11 && !over12 |=> sel_q == FLUT_SEL_11 && table_duty == $past(dv11))
    else $error("entry 11 duty not driven");

  chk_entry12_wins: assert property (
    over12 |=> sel_q == FLUT_SEL_12 && table_duty == $past(dv12))
    else $error("entry 12 duty not driven");

  chk_no_entry_idle: assert property (
    !over11 && !over12 |=> !table_hit && table_duty == 8'h00)
    else $error("duty driven with no entry exceeded");

  chk_unsigned_thr: assert property (
    remote_temp == 9'h1ff && offset_q == 8'h00 && thr12_q != 8'hff |-> over12)
    else $error("threshold treated as signed");

  chk_offset_shift: assert property (
    temp_hr && offset_q != 8'h00 &&
      {1'b0, remote_temp} == {2'b00, thr12_q[6:0], thr12_q[7]} + {1'b0, offset_q, 1'b0}
      |-> !over12)
    else $error("offset not applied to limit");

  chk_duty_ext_low: assert property (
    !duty_hr [*2] |-> duty11_q[7:6] == 2'b00 && duty12_q[7:6] == 2'b00)
    else $error("duty extended bits set in low resolution");

  chk_lr_duty_write: assert property (
    wr_acc && wr_en && idx == `FLUT_IDX_DUTY11 && !duty_hr |=> duty11_q[7:6] == 2'b00)
    else $error("low resolution write set duty extended bits");

  chk_hr_duty_word: assert property (
    ext_en && over12 |=> table_duty == $past(duty12_q))
    else $error("extended duty word not formed");

  chk_ext_freq_gate: assert property (
    !pwm_22k5 |=> table_duty[7:6] == 2'b00)
    else $error("extended bits active off 22.5 khz");

  chk_lr_duty_base: assert property (
    !ext_en && over12 |=> table_duty == (8'h3f & $past(duty12_q)))
    else $error("low resolution duty not from base bits");

endmodule

// ### dv/flut_tb.sv
// self-checking testbench of the upper fan table entries
`include "flut_regs.svh"

module testbench
  import flut_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------------------
  // signals and bench state
  // ----------------------------------------------------------------------------
  logic        clk;             // 40 mhz clock
  logic        rst_n;           // synchronous reset, active low
  logic [9:0]  avs_address;     // byte address
  logic        avs_read;        // read request
  logic        avs_write;       // write request
  logic [31:0] avs_writedata;   // write data
  logic [3:0]  avs_byteenable;  // byte enables
  logic [31:0] avs_readdata;    // read data
  logic        avs_waitrequest; // slave stall
  logic [8:0]  remote_temp;     // reading in half degrees
  logic        table_hit;       // an upper entry exceeded
  logic [7:0]  table_duty;      // winning duty
  logic [31:0] lfsr_q;          // random source
  flut_byte_t  thr11_m, duty11_m, thr12_m, duty12_m, lock_m, off_m, mode_m; // shadow regs
  int          miscompares;     // mismatches seen
  int          n_tests;         // comparisons made

  flut_upper DUT (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .remote_temp(remote_temp), .table_hit(table_hit), .table_duty(table_duty));

  // clock generator
  always #12.5 clk = ~clk;

  // ----------------------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    for (int i = 0; i < 8; i++) begin
      lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    end
    return lfsr_q;
  endfunction

  function automatic void sanitize();
    if (!mode_m[0]) begin thr11_m[7] = 1'b0; thr12_m[7] = 1'b0; end
    if (!mode_m[1]) begin duty11_m[7:6] = 2'b00; duty12_m[7:6] = 2'b00; end
  endfunction

  function automatic void model_reset();
    thr11_m = 8'h7f; thr12_m = 8'h7f; duty11_m = 8'h3f; duty12_m = 8'h3f;
    lock_m = 8'h00; off_m = 8'h00; mode_m = 8'h00;
  endfunction

  // entry writes need the lock bit
  function automatic void model_write(flut_byte_t idx, flut_byte_t d);
    case (idx)
      `FLUT_IDX_LOCK:   lock_m = d;
      `FLUT_IDX_OFFSET: off_m = d;
      `FLUT_IDX_MODE:   mode_m = d & 8'h07;
      `FLUT_IDX_THR11:  if (lock_m[5]) thr11_m = d;
      `FLUT_IDX_DUTY11: if (lock_m[5]) duty11_m = d;
      `FLUT_IDX_THR12:  if (lock_m[5]) thr12_m = d;
      `FLUT_IDX_DUTY12: if (lock_m[5]) duty12_m = d;
      default: ;
    endcase
    sanitize();
  endfunction

  function automatic logic [9:0] lim_h(flut_byte_t t);
    if (mode_m[0]) return {2'b00, t[6:0], t[7]} + {1'b0, off_m, 1'b0};
    return ({3'b000, t[6:0]} + {2'b00, off_m}) << 1;
  endfunction

  function automatic logic gt(logic [8:0] tp, flut_byte_t t);
    logic [9:0] l;
    l = lim_h(t);
    return mode_m[0] ? ({1'b0, tp} > l) : ({1'b0, tp[8:1]} > l[9:1]);
  endfunction

  function automatic flut_byte_t duty_of(flut_byte_t d);
    return (mode_m[1] && mode_m[2]) ? d : {2'b00, d[5:0]};
  endfunction

  // entry 12 wins when both exceeded
  function automatic logic [8:0] exp_out(logic [8:0] tp);
    if (gt(tp, thr12_m)) return {1'b1, duty_of(duty12_m)};
    if (gt(tp, thr11_m)) return {1'b1, duty_of(duty11_m)};
    return 9'h000;
  endfunction

  function automatic flut_byte_t exp_reg(flut_byte_t idx);
    case (idx)
      `FLUT_IDX_LOCK:   return lock_m;
      `FLUT_IDX_OFFSET: return off_m;
      `FLUT_IDX_MODE:   return mode_m;
      `FLUT_IDX_THR11:  return thr11_m;
      `FLUT_IDX_DUTY11: return duty11_m;
      `FLUT_IDX_THR12:  return thr12_m;
      `FLUT_IDX_DUTY12: return duty12_m;
      `FLUT_IDX_STATUS: return gt(remote_temp, thr12_m) ? 8'h02 :
                               gt(remote_temp, thr11_m) ? 8'h01 : 8'h00;
      default:          return 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------------
  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input flut_byte_t idx, input flut_byte_t wd,
                     input logic be0, output logic [31:0] rd);
    logic got;
    got = 1'b0;
    rd = 32'h0000_0000;
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {rnd() & 32'hffffff00} | {24'h000000, wd};
    avs_byteenable <= {3'b000, be0};
    for (int i = 0; i < 16 && !got; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) begin
        got = 1'b1;
        rd = avs_readdata;
      end
    end
    if (!got) begin
      miscompares++;
      tally_and_finish();
    end else begin
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (wr && be0) model_write(idx, wd);
    end
  endtask

  task automatic wr(input flut_byte_t idx, input flut_byte_t d);
    logic [31:0] v;
    bus(1'b1, idx, d, 1'b1, v);
  endtask

  task automatic rd_chk(input flut_byte_t idx);
    logic [31:0] v;
    bus(1'b0, idx, 8'h00, 1'b1, v);
    check($sformatf("reg %h", idx), {1'b0, v[7:0]}, {1'b0, exp_reg(idx)});
    check("readdata_upper", {8'h00, |v[31:8]}, 9'h000);
  endtask

  task automatic out_chk(input logic [8:0] tp);
    @(posedge clk);
    remote_temp <= tp;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("table_out", {table_hit, table_duty}, exp_out(tp));
  endtask

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    flut_byte_t idx_list[9];
    logic [31:0] v;
    logic [31:0] r;
    logic [9:0]  t10;
    clk = 1'b0; rst_n = 1'b0; avs_address = '0; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = '0; avs_byteenable = '0; remote_temp = '0;
    lfsr_q = 32'd83763; miscompares = 0; n_tests = 0;
    idx_list = '{8'h4a, 8'h4e, 8'h64, 8'h65, 8'h66, 8'h67, 8'h70, 8'h71, 8'h10};
    model_reset();
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    foreach (idx_list[i]) rd_chk(idx_list[i]); // reset values and unmapped read
    check("table_reset", {table_hit, table_duty}, 9'h000);
    $display("test reset_values done");
    wr(`FLUT_IDX_THR11, 8'h12);
    wr(`FLUT_IDX_DUTY12, 8'h05);
    rd_chk(`FLUT_IDX_THR11);
    rd_chk(`FLUT_IDX_DUTY12);
    wr(8'h10, 8'hff);
    rd_chk(8'h10);
    wr(`FLUT_IDX_LOCK, 8'h20);
    bus(1'b1, `FLUT_IDX_THR12, 8'h01, 1'b0, v);
    rd_chk(`FLUT_IDX_THR12);
    $display("test locked_writes done");
    for (int n = 0; n < 64; n++) begin
      r = rnd();
      wr(`FLUT_IDX_MODE, {r[7:3], n[2:0]});
      wr(`FLUT_IDX_OFFSET, (n % 5 == 0) ? 8'h00 : {2'b00, r[13:8]});
      for (int k = 0; k < 4; k++) wr(8'h64 + k[7:0], rnd());
      for (int k = 0; k < 4; k++) rd_chk(8'h64 + k[7:0]);
      rd_chk(`FLUT_IDX_MODE);
      r = rnd();
      t10 = lim_h(r[30] ? thr12_m : thr11_m) + {8'h00, r[27:26]} - 10'h001;
      out_chk(r[31] ? r[24:16] : t10[8:0]);
      rd_chk(`FLUT_IDX_STATUS);
    end
    $display("test random_table done");
    wr(`FLUT_IDX_MODE, 8'h00);
    wr(`FLUT_IDX_THR11, 8'hff);
    wr(`FLUT_IDX_DUTY11, 8'hff);
    wr(`FLUT_IDX_MODE, 8'h07);
    wr(`FLUT_IDX_OFFSET, 8'h00);
    rd_chk(`FLUT_IDX_THR11);
    rd_chk(`FLUT_IDX_DUTY11);
    out_chk(9'h1ff);
    wr(`FLUT_IDX_LOCK, 8'h00);
    wr(`FLUT_IDX_THR11, 8'h80);
    wr(`FLUT_IDX_DUTY11, 8'hc1);
    rd_chk(`FLUT_IDX_THR11);
    rd_chk(`FLUT_IDX_DUTY11);
    $display("test mode_switch done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("table_rereset", {table_hit, table_duty}, 9'h000);
    @(posedge clk);
    rst_n <= 1'b1;
    model_reset();
    rd_chk(`FLUT_IDX_DUTY11);
    $display("test second_reset done");
    tally_and_finish();
  end
endmodule
